// ### rtl/branch_call_move_exec.sv
// Purpose: fetch and execute branch, call, jump, copy, code-read and external transfers
// Assumes: code and external memories answer combinationally to the registered address
// Notes: internal ram is 128 bytes; indirect addresses use the low seven bits
`timescale 1ns/1ps
module branch_call_move_exec (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] code_data_i,
  input wire logic [7:0] xdata_rdata_i,
  output logic [15:0] code_addr_o,
  output logic [15:0] xdata_addr_o,
  output logic [7:0] xdata_wdata_o,
  output logic xdata_wr_o,
  output logic xdata_rd_o,
  output logic instr_done_o,
  output logic [15:0] pc_o,
  output logic [7:0] acc_o,
  output logic [7:0] sp_o,
  output logic [15:0] data_pointer_o,
  output logic carry_o
);
  typedef enum logic [6:0] {
    S_FETCH = 7'h01,
    S_OPC = 7'h02,
    S_B2 = 7'h04,
    S_B3 = 7'h08,
    S_EXEC = 7'h10,
    S_MEM = 7'h20,
    S_WAIT = 7'h40
  } state_type;

  state_type state_reg;
  logic [7:0] op_reg, b2_reg, b3_reg;
  logic [15:0] pc_reg;
  logic [7:0] acc_reg, b_reg, psw_reg, sp_reg, dph_reg, dpl_reg;
  logic [3:0] cnt_reg;
  logic [7:0] ram [0:127];
  logic [1:0] len_reg, cyc_reg;
  bcm_pkg::op_class_type cls_reg;
  bcm_pkg::src_sel_type src_reg;
  bcm_pkg::dst_sel_type dst_reg;
  logic [1:0] dec_len, dec_cyc;
  bcm_pkg::op_class_type dec_cls;
  bcm_pkg::src_sel_type dec_src;
  bcm_pkg::dst_sel_type dec_dst;

  op_decoder u_dec (
    .opcode_i(code_data_i),
    .len_o(dec_len),
    .cycles_o(dec_cyc),
    .class_o(dec_cls),
    .src_o(dec_src),
    .dst_o(dec_dst)
  );

  function automatic logic [7:0] read_dir(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (!a[7]) begin
      v = ram[a[6:0]];
    end else begin
      case (a)
        bcm_pkg::ADDR_ACC: v = acc_reg;
        bcm_pkg::ADDR_B: v = b_reg;
        bcm_pkg::ADDR_PSW: v = psw_reg;
        bcm_pkg::ADDR_SP: v = sp_reg;
        bcm_pkg::ADDR_DPL: v = dpl_reg;
        bcm_pkg::ADDR_DPH: v = dph_reg;
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  // unsigned byte offset onto a 16-bit base, carry reaching the high byte
  function automatic logic [15:0] add_base(input logic [15:0] base, input logic [7:0] off);
    return base + {8'h00, off};
  endfunction

  logic [7:0] bank_addr, ptr_val, src_val, bit_byte, bit_byte_val, sp_inc;
  logic bit_val, exec_st, mem_st, wr_en, wr_ind;
  logic [7:0] wr_addr, wr_data;
  logic [3:0] limit;
  logic [15:0] data_pointer;

  assign exec_st = (state_reg == S_EXEC);
  assign mem_st = (state_reg == S_MEM);
  assign data_pointer = {dph_reg, dpl_reg};
  assign sp_inc = sp_reg + 8'h01;
  assign bank_addr = {3'b000, psw_reg[bcm_pkg::BANK_MSB:bcm_pkg::BANK_LSB], op_reg[2:0]};
  assign ptr_val = ram[{2'b00, psw_reg[bcm_pkg::BANK_MSB:bcm_pkg::BANK_LSB], 2'b00, op_reg[0]}];
  assign bit_byte = b2_reg[7] ? {b2_reg[7:3], 3'b000} : bcm_pkg::BIT_RAM_BASE + {4'h0, b2_reg[6:3]};
  // a process, not a continuous assign, so ram and register updates re-evaluate the read
  always_comb begin
    bit_byte_val = read_dir(bit_byte);
  end
  assign bit_val = bit_byte_val[b2_reg[2:0]];
  assign limit = 4'(cyc_reg * bcm_pkg::MC_CLOCKS);

  // copy form with the accumulator as both ends is simply a read of itself here
  always_comb begin
    case (src_reg)
      bcm_pkg::SRC_A: src_val = acc_reg;
      bcm_pkg::SRC_RN: src_val = read_dir(bank_addr);
      bcm_pkg::SRC_DIR2: src_val = read_dir(b2_reg);
      bcm_pkg::SRC_IND: src_val = ram[ptr_val[6:0]];
      bcm_pkg::SRC_IMM2: src_val = b2_reg;
      bcm_pkg::SRC_IMM3: src_val = b3_reg;
      default: src_val = 8'h00;
    endcase
  end

  // single write port into ram and special registers
  always_comb begin
    wr_en = 1'b0;
    wr_ind = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    if (exec_st && cls_reg == bcm_pkg::CLS_COPY) begin
      wr_en = 1'b1;
      wr_data = src_val;
      case (dst_reg)
        bcm_pkg::DST_A: wr_addr = bcm_pkg::ADDR_ACC;
        bcm_pkg::DST_RN: wr_addr = bank_addr;
        bcm_pkg::DST_DIR2: wr_addr = b2_reg;
        bcm_pkg::DST_DIR3: wr_addr = b3_reg;
        bcm_pkg::DST_IND: begin
          wr_ind = 1'b1;
          wr_addr = ptr_val;
        end
        default: wr_addr = bcm_pkg::ADDR_ACC;
      endcase
    end else if (exec_st && cls_reg == bcm_pkg::CLS_C_TO_BIT) begin
      wr_en = 1'b1;
      wr_addr = bit_byte;
      wr_data = bit_byte_val;
      wr_data[b2_reg[2:0]] = psw_reg[bcm_pkg::CARRY_POS];
    end else if ((exec_st || mem_st) && cls_reg == bcm_pkg::CLS_LONG_SUBROUTINE_CALL) begin
      wr_en = 1'b1;
      wr_ind = 1'b1;
      wr_addr = sp_inc;
      wr_data = exec_st ? pc_reg[7:0] : pc_reg[15:8];
    end
  end

  function automatic logic sfr_hit(input logic [7:0] a);
    return wr_en && !wr_ind && (wr_addr == a);
  endfunction

  always_ff @(posedge clock_i) begin
    if (wr_en && (wr_ind || !wr_addr[7])) begin
      ram[wr_addr[6:0]] <= wr_data;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= S_FETCH;
      cnt_reg <= 4'h0;
      op_reg <= 8'h00;
      b2_reg <= 8'h00;
      b3_reg <= 8'h00;
      len_reg <= 2'h1;
      cyc_reg <= 2'h1;
      cls_reg <= bcm_pkg::CLS_NOP;
      src_reg <= bcm_pkg::SRC_A;
      dst_reg <= bcm_pkg::DST_A;
      instr_done_o <= 1'b0;
    end else begin
      cnt_reg <= (state_reg == S_FETCH) ? 4'h1 : cnt_reg + 4'h1;
      instr_done_o <= 1'b0;
      case (state_reg)
        S_FETCH: state_reg <= S_OPC;
        S_OPC: begin
          op_reg <= code_data_i;
          len_reg <= dec_len;
          cyc_reg <= dec_cyc;
          cls_reg <= dec_cls;
          src_reg <= dec_src;
          dst_reg <= dec_dst;
          state_reg <= (dec_len == 2'h1) ? S_EXEC : S_B2;
        end
        S_B2: begin
          b2_reg <= code_data_i;
          state_reg <= (len_reg == 2'h3) ? S_B3 : S_EXEC;
        end
        S_B3: begin
          b3_reg <= code_data_i;
          state_reg <= S_EXEC;
        end
        S_EXEC: begin
          case (cls_reg)
            bcm_pkg::CLS_LONG_SUBROUTINE_CALL, bcm_pkg::CLS_CODE_DP, bcm_pkg::CLS_CODE_PC,
            bcm_pkg::CLS_XRD_RI, bcm_pkg::CLS_XRD_DP: state_reg <= S_MEM;
            default: state_reg <= S_WAIT;
          endcase
        end
        S_MEM: state_reg <= S_WAIT;
        S_WAIT: begin
          if (cnt_reg >= limit - 4'h1) begin
            instr_done_o <= 1'b1;
            state_reg <= S_FETCH;
          end
        end
        default: state_reg <= S_FETCH;
      endcase
    end
  end

  // program counter advances with every byte fetched
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pc_reg <= bcm_pkg::PC_RESET;
    end else if (state_reg == S_OPC || state_reg == S_B2 || state_reg == S_B3) begin
      pc_reg <= pc_reg + 16'h0001;
    end else if (exec_st && cls_reg == bcm_pkg::CLS_JZ && acc_reg == 8'h00) begin
      pc_reg <= pc_reg + {{8{b2_reg[7]}}, b2_reg};
    end else if (exec_st && cls_reg == bcm_pkg::CLS_LONG_JUMP) begin
      pc_reg <= {b2_reg, b3_reg};
    end else if (mem_st && cls_reg == bcm_pkg::CLS_LONG_SUBROUTINE_CALL) begin
      pc_reg <= {b2_reg, b3_reg};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      code_addr_o <= bcm_pkg::PC_RESET;
    end else if (state_reg == S_FETCH) begin
      code_addr_o <= pc_reg;
    end else if (state_reg == S_OPC || state_reg == S_B2) begin
      code_addr_o <= pc_reg + 16'h0001;
    end else if (exec_st && cls_reg == bcm_pkg::CLS_CODE_DP) begin
      code_addr_o <= add_base(data_pointer, acc_reg);
    end else if (exec_st && cls_reg == bcm_pkg::CLS_CODE_PC) begin
      code_addr_o <= add_base(pc_reg, acc_reg);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      xdata_addr_o <= 16'h0000;
      xdata_wdata_o <= 8'h00;
      xdata_wr_o <= 1'b0;
      xdata_rd_o <= 1'b0;
    end else begin
      xdata_wr_o <= 1'b0;
      xdata_rd_o <= 1'b0;
      if (exec_st) begin
        case (cls_reg)
          bcm_pkg::CLS_XRD_RI: begin
            xdata_addr_o <= {8'h00, ptr_val};
            xdata_rd_o <= 1'b1;
          end
          bcm_pkg::CLS_XRD_DP: begin
            xdata_addr_o <= data_pointer;
            xdata_rd_o <= 1'b1;
          end
          bcm_pkg::CLS_XWR_RI: begin
            xdata_addr_o <= {8'h00, ptr_val};
            xdata_wdata_o <= acc_reg;
            xdata_wr_o <= 1'b1;
          end
          bcm_pkg::CLS_XWR_DP: begin
            xdata_addr_o <= data_pointer;
            xdata_wdata_o <= acc_reg;
            xdata_wr_o <= 1'b1;
          end
          default: xdata_wr_o <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      acc_reg <= bcm_pkg::BYTE_RESET;
    end else if (sfr_hit(bcm_pkg::ADDR_ACC)) begin
      acc_reg <= wr_data;
    end else if (mem_st && (cls_reg == bcm_pkg::CLS_CODE_DP || cls_reg == bcm_pkg::CLS_CODE_PC)) begin
      acc_reg <= code_data_i;
    end else if (mem_st && (cls_reg == bcm_pkg::CLS_XRD_RI || cls_reg == bcm_pkg::CLS_XRD_DP)) begin
      acc_reg <= xdata_rdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      b_reg <= bcm_pkg::BYTE_RESET;
    end else if (sfr_hit(bcm_pkg::ADDR_B)) begin
      b_reg <= wr_data;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      psw_reg <= bcm_pkg::BYTE_RESET;
    end else if (sfr_hit(bcm_pkg::ADDR_PSW)) begin
      psw_reg <= wr_data;
    end else if (exec_st && cls_reg == bcm_pkg::CLS_BIT_TO_C) begin
      psw_reg[bcm_pkg::CARRY_POS] <= bit_val;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sp_reg <= bcm_pkg::SP_RESET;
    end else if (sfr_hit(bcm_pkg::ADDR_SP)) begin
      sp_reg <= wr_data;
    end else if ((exec_st || mem_st) && cls_reg == bcm_pkg::CLS_LONG_SUBROUTINE_CALL) begin
      sp_reg <= sp_inc;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dph_reg <= bcm_pkg::BYTE_RESET;
      dpl_reg <= bcm_pkg::BYTE_RESET;
    end else if (exec_st && cls_reg == bcm_pkg::CLS_DATA_POINTER_LOAD) begin
      dph_reg <= b2_reg;
      dpl_reg <= b3_reg;
    end else begin
      if (sfr_hit(bcm_pkg::ADDR_DPH)) begin
        dph_reg <= wr_data;
      end
      if (sfr_hit(bcm_pkg::ADDR_DPL)) begin
        dpl_reg <= wr_data;
      end
    end
  end

  assign pc_o = pc_reg;
  assign acc_o = acc_reg;
  assign sp_o = sp_reg;
  assign data_pointer_o = data_pointer;
  assign carry_o = psw_reg[bcm_pkg::CARRY_POS];
endmodule

// ### rtl/bcm_pkg.sv
// Purpose: shared constants and types for the branch/call/copy execution block
// Assumes: standard single-byte opcode map of the 8-bit core
// Notes: one machine cycle is a fixed number of core clocks
package bcm_pkg;
  // core clocks per machine cycle
  localparam logic [3:0] MC_CLOCKS = 4'h6;
  // stack pointer and register reset values
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // special register direct addresses
  localparam logic [7:0] ADDR_ACC = 8'he0;
  localparam logic [7:0] ADDR_B = 8'hf0;
  localparam logic [7:0] ADDR_PSW = 8'hd0;
  localparam logic [7:0] ADDR_SP = 8'h81;
  localparam logic [7:0] ADDR_DPL = 8'h82;
  localparam logic [7:0] ADDR_DPH = 8'h83;
  // base of bit-addressable internal ram
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  // status word field positions
  localparam int CARRY_POS = 7;
  localparam int BANK_LSB = 3;
  localparam int BANK_MSB = 4;

  typedef enum logic [3:0] {
    CLS_NOP = 4'h0,
    CLS_JZ = 4'h1,
    CLS_LONG_SUBROUTINE_CALL = 4'h2,
    CLS_LONG_JUMP = 4'h3,
    CLS_COPY = 4'h4,
    CLS_BIT_TO_C = 4'h5,
    CLS_C_TO_BIT = 4'h6,
    CLS_DATA_POINTER_LOAD = 4'h7,
    CLS_CODE_DP = 4'h8,
    CLS_CODE_PC = 4'h9,
    CLS_XRD_RI = 4'ha,
    CLS_XRD_DP = 4'hb,
    CLS_XWR_RI = 4'hc,
    CLS_XWR_DP = 4'hd
  } op_class_type;

  typedef enum logic [2:0] {
    SRC_A = 3'h0,
    SRC_RN = 3'h1,
    SRC_DIR2 = 3'h2,
    SRC_IND = 3'h3,
    SRC_IMM2 = 3'h4,
    SRC_IMM3 = 3'h5
  } src_sel_type;

  typedef enum logic [2:0] {
    DST_A = 3'h0,
    DST_RN = 3'h1,
    DST_DIR2 = 3'h2,
    DST_DIR3 = 3'h3,
    DST_IND = 3'h4
  } dst_sel_type;
endpackage

// ### rtl/op_decoder.sv
// Purpose: opcode to length, machine cycles, class and operand selectors
// Assumes: opcode stable for the cycle it is sampled
// Notes: unlisted opcodes decode as one-byte one-cycle no-ops
`timescale 1ns/1ps
module op_decoder (
  input wire logic [7:0] opcode_i,
  output logic [1:0] len_o,
  output logic [1:0] cycles_o,
  output bcm_pkg::op_class_type class_o,
  output bcm_pkg::src_sel_type src_o,
  output bcm_pkg::dst_sel_type dst_o
);
  always_comb begin
    len_o = 2'h1;
    cycles_o = 2'h1;
    class_o = bcm_pkg::CLS_COPY;
    src_o = bcm_pkg::SRC_A;
    dst_o = bcm_pkg::DST_A;
    casez (opcode_i)
      8'h60: begin class_o = bcm_pkg::CLS_JZ; len_o = 2'h2; cycles_o = 2'h2; end
      8'h12: begin class_o = bcm_pkg::CLS_LONG_SUBROUTINE_CALL; len_o = 2'h3; cycles_o = 2'h2; end
      8'h02: begin class_o = bcm_pkg::CLS_LONG_JUMP; len_o = 2'h3; cycles_o = 2'h2; end
      8'ha2: begin class_o = bcm_pkg::CLS_BIT_TO_C; len_o = 2'h2; end
      8'h92: begin class_o = bcm_pkg::CLS_C_TO_BIT; len_o = 2'h2; cycles_o = 2'h2; end
      8'h90: begin class_o = bcm_pkg::CLS_DATA_POINTER_LOAD; len_o = 2'h3; cycles_o = 2'h2; end
      8'h93: begin class_o = bcm_pkg::CLS_CODE_DP; cycles_o = 2'h2; end
      8'h83: begin class_o = bcm_pkg::CLS_CODE_PC; cycles_o = 2'h2; end
      8'b1110_001?: begin class_o = bcm_pkg::CLS_XRD_RI; cycles_o = 2'h2; end
      8'he0: begin class_o = bcm_pkg::CLS_XRD_DP; cycles_o = 2'h2; end
      8'b1111_001?: begin class_o = bcm_pkg::CLS_XWR_RI; cycles_o = 2'h2; end
      8'hf0: begin class_o = bcm_pkg::CLS_XWR_DP; cycles_o = 2'h2; end
      // the fifteen byte copy forms
      8'b1110_1???: src_o = bcm_pkg::SRC_RN;
      8'he5: begin src_o = bcm_pkg::SRC_DIR2; len_o = 2'h2; end
      8'b1110_011?: src_o = bcm_pkg::SRC_IND;
      8'h74: begin src_o = bcm_pkg::SRC_IMM2; len_o = 2'h2; end
      8'b1111_1???: dst_o = bcm_pkg::DST_RN;
      8'b1010_1???: begin
        src_o = bcm_pkg::SRC_DIR2; dst_o = bcm_pkg::DST_RN; len_o = 2'h2; cycles_o = 2'h2;
      end
      8'b0111_1???: begin src_o = bcm_pkg::SRC_IMM2; dst_o = bcm_pkg::DST_RN; len_o = 2'h2; end
      8'hf5: begin dst_o = bcm_pkg::DST_DIR2; len_o = 2'h2; end
      8'b1000_1???: begin
        src_o = bcm_pkg::SRC_RN; dst_o = bcm_pkg::DST_DIR2; len_o = 2'h2; cycles_o = 2'h2;
      end
      8'h85: begin src_o = bcm_pkg::SRC_DIR2; dst_o = bcm_pkg::DST_DIR3; len_o = 2'h3; end
      8'b1000_011?: begin
        src_o = bcm_pkg::SRC_IND; dst_o = bcm_pkg::DST_DIR2; len_o = 2'h2; cycles_o = 2'h2;
      end
      8'h75: begin
        src_o = bcm_pkg::SRC_IMM3; dst_o = bcm_pkg::DST_DIR2; len_o = 2'h3; cycles_o = 2'h2;
      end
      8'b1111_011?: dst_o = bcm_pkg::DST_IND;
      8'b1010_011?: begin
        src_o = bcm_pkg::SRC_DIR2; dst_o = bcm_pkg::DST_IND; len_o = 2'h2; cycles_o = 2'h2;
      end
      8'b0111_011?: begin src_o = bcm_pkg::SRC_IMM2; dst_o = bcm_pkg::DST_IND; len_o = 2'h2; end
      default: class_o = bcm_pkg::CLS_NOP;
    endcase
  end
endmodule

// ### testbench/ext_memories.sv
// Purpose: program memory and external data memory seen by the core
// Assumes: both memories answer combinationally to the registered addresses
// Notes: the read bus shows a toggling pattern whenever no read strobe is high
`timescale 1ns/1ps
module ext_memories (
  input wire logic clock_i,
  input wire logic [15:0] code_addr_i,
  input wire logic [15:0] xdata_addr_i,
  input wire logic [7:0] xdata_wdata_i,
  input wire logic xdata_wr_i,
  input wire logic xdata_rd_i,
  output logic [7:0] code_data_o,
  output logic [7:0] xdata_rdata_o
);
  logic [7:0] code [0:65535];
  logic [7:0] xmem [0:65535];
  logic [7:0] last_reg = 8'h00;

  assign code_data_o = code[code_addr_i];
  // released bus inverts its last value so a stale byte is never mistaken for data
  assign xdata_rdata_o = xdata_rd_i ? xmem[xdata_addr_i] : ~last_reg;

  always_ff @(posedge clock_i) begin
    if (xdata_wr_i) begin
      xmem[xdata_addr_i] <= xdata_wdata_i;
    end
    last_reg <= xdata_rdata_o;
  end
endmodule

// ### testbench/branch_call_move_exec_checker.sv
// Purpose: port-level assertions for the branch, call, copy and transfer block
// Assumes: opcode is on code_data_i the cycle after instr_done_o
// Notes: one machine cycle is six clocks
`timescale 1ns/1ps
module branch_call_move_exec_checker (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] code_data_i,
  input wire logic [7:0] xdata_rdata_i,
  input wire logic [15:0] code_addr_o,
  input wire logic [15:0] xdata_addr_o,
  input wire logic [7:0] xdata_wdata_o,
  input wire logic xdata_wr_o,
  input wire logic xdata_rd_o,
  input wire logic instr_done_o,
  input wire logic [15:0] pc_o,
  input wire logic [7:0] acc_o,
  input wire logic [7:0] sp_o,
  input wire logic [15:0] data_pointer_o,
  input wire logic carry_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  property p_jz;
    logic [15:0] b;
    logic [7:0] a;
    logic [7:0] r;
    instr_done_o ##1 (code_data_i == 8'h60, b = code_addr_o, a = acc_o)
      ##1 (1'b1, r = code_data_i)
      |-> ##10 (instr_done_o && acc_o == a
        && pc_o == b + 16'h0002 + ((a == 8'h00) ? {{8{r[7]}}, r} : 16'h0000));
  endproperty
  property p_long_subroutine_call;
    logic [7:0] s;
    logic [7:0] hi;
    logic [7:0] lo;
    instr_done_o ##1 (code_data_i == 8'h12, s = sp_o) ##1 (1'b1, hi = code_data_i)
      ##1 (1'b1, lo = code_data_i)
      |-> ##9 (instr_done_o && pc_o == {hi, lo} && sp_o == s + 8'h02);
  endproperty
  property p_long_jump;
    logic [7:0] hi;
    logic [7:0] lo;
    instr_done_o ##1 (code_data_i == 8'h02) ##1 (1'b1, hi = code_data_i)
      ##1 (1'b1, lo = code_data_i) |-> ##9 (instr_done_o && pc_o == {hi, lo});
  endproperty
  property p_data_pointer_load;
    logic [7:0] hi;
    logic [7:0] lo;
    instr_done_o ##1 (code_data_i == 8'h90) ##1 (1'b1, hi = code_data_i)
      ##1 (1'b1, lo = code_data_i) |-> ##9 (instr_done_o && data_pointer_o == {hi, lo});
  endproperty
  property p_code_dp;
    logic [15:0] d;
    logic [15:0] b;
    instr_done_o ##1 (code_data_i == 8'h93, b = data_pointer_o,
      d = data_pointer_o + {8'h00, acc_o})
      |-> ##[2:10] (code_addr_o == d) ##[1:9] (instr_done_o && data_pointer_o == b);
  endproperty
  property p_c_to_bit;
    logic c;
    instr_done_o ##1 (code_data_i == 8'h92, c = carry_o) |-> ##11 (instr_done_o && carry_o == c);
  endproperty
  property p_xrd;
    logic [7:0] d;
    (xdata_rd_o, d = xdata_rdata_i) |=> acc_o == d;
  endproperty

  AST_JZ_TARGET: assert property (p_jz) else $error("branch on zero target wrong");
  AST_LONG_SUBROUTINE_CALL_TARGET: assert property (p_long_subroutine_call) else $error("long call pc or sp wrong");
  AST_LONG_JUMP_TARGET: assert property (p_long_jump) else $error("long jump target wrong");
  AST_DATA_POINTER_LOAD: assert property (p_data_pointer_load) else $error("pointer load wrong");
  AST_CODE_DP_ADDR: assert property (p_code_dp) else $error("code read address wrong");
  AST_C_TO_BIT: assert property (p_c_to_bit) else $error("carry to bit timing wrong");
  AST_BIT_TO_C_LEN: assert property (instr_done_o ##1 code_data_i == 8'ha2 |-> ##5 instr_done_o)
    else $error("bit to carry length wrong");
  AST_XRD_ACC: assert property (p_xrd) else $error("external read not loaded");
  AST_XWR_DATA: assert property (xdata_wr_o |-> xdata_wdata_o == acc_o)
    else $error("external write data wrong");
  AST_XFER_GAP: assert property ((xdata_rd_o || xdata_wr_o) |=> !(xdata_rd_o || xdata_wr_o) [*8])
    else $error("external strobes too close");

  COV_JZ: cover property (instr_done_o ##1 code_data_i == 8'h60 && acc_o == 8'h00);
  COV_LONG_SUBROUTINE_CALL: cover property (instr_done_o ##1 code_data_i == 8'h12);
  COV_XRD: cover property (xdata_rd_o);
  COV_XWR: cover property (xdata_wr_o);
endmodule

bind branch_call_move_exec branch_call_move_exec_checker chk (.clock_i(clock_i), .rst_i(rst_i),
  .code_data_i(code_data_i), .xdata_rdata_i(xdata_rdata_i), .code_addr_o(code_addr_o),
  .xdata_addr_o(xdata_addr_o), .xdata_wdata_o(xdata_wdata_o), .xdata_wr_o(xdata_wr_o),
  .xdata_rd_o(xdata_rd_o), .instr_done_o(instr_done_o), .pc_o(pc_o), .acc_o(acc_o),
  .sp_o(sp_o), .data_pointer_o(data_pointer_o), .carry_o(carry_o));

// ### testbench/branch_call_move_exec_bench.sv
// Purpose: runs a random-valued program twice and compares with an instruction model
// Assumes: instr_done_o pulses once at the end of every instruction
// Notes: the second pass starts with a reset in mid-run
`timescale 1ns/1ps
module branch_call_move_exec_bench;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] code_data, xdata_rdata, xdata_wdata, acc_o, sp_o;
  logic [15:0] code_addr, xdata_addr, pc_o, data_pointer_o;
  logic xdata_wr, xdata_rd, instr_done_o, carry_o;
  logic [15:0] m_pc, m_dp;
  logic [7:0] m_acc, m_sp;
  logic m_cy;
  logic [7:0] ram [0:127];
  logic [7:0] cm [0:65535];
  logic [7:0] xm [logic [15:0]];
  int err_count = 0;
  int tests_run = 0;

  branch_call_move_exec dut (.clock_i(clock_i), .rst_i(rst_i), .code_data_i(code_data),
    .xdata_rdata_i(xdata_rdata), .code_addr_o(code_addr), .xdata_addr_o(xdata_addr),
    .xdata_wdata_o(xdata_wdata), .xdata_wr_o(xdata_wr), .xdata_rd_o(xdata_rd),
    .instr_done_o(instr_done_o), .pc_o(pc_o), .acc_o(acc_o), .sp_o(sp_o),
    .data_pointer_o(data_pointer_o), .carry_o(carry_o));
  ext_memories mem (.clock_i(clock_i), .code_addr_i(code_addr), .xdata_addr_i(xdata_addr),
    .xdata_wdata_i(xdata_wdata), .xdata_wr_i(xdata_wr), .xdata_rd_i(xdata_rd),
    .code_data_o(code_data), .xdata_rdata_o(xdata_rdata));

  initial begin
    forever #25 clock_i = ~clock_i;
  end

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_clocks(input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      err_count++;
      $display("BAD clocks expected %0d seen %0d", exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one instruction of the model; returns its machine cycles
  task automatic step(output int cyc);
    logic [7:0] op, b2, b3;
    op = cm[m_pc];
    b2 = cm[m_pc + 16'h1];
    b3 = cm[m_pc + 16'h2];
    cyc = 2;
    case (op)
      8'h74: begin m_acc = b2; m_pc += 16'h2; cyc = 1; end
      8'hf8: begin ram[0] = m_acc; m_pc += 16'h1; cyc = 1; end
      8'he8: begin m_acc = ram[0]; m_pc += 16'h1; cyc = 1; end
      8'h75: begin ram[b2[6:0]] = b3; m_pc += 16'h3; end
      8'h85: begin ram[b3[6:0]] = ram[b2[6:0]]; m_pc += 16'h3; cyc = 1; end
      8'he5: begin m_acc = ram[b2[6:0]]; m_pc += 16'h2; cyc = 1; end
      8'h90: begin m_dp = {b2, b3}; m_pc += 16'h3; end
      8'hf0: begin xm[m_dp] = m_acc; m_pc += 16'h1; end
      8'he0: begin m_acc = xm[m_dp]; m_pc += 16'h1; end
      8'hf2: begin xm[{8'h00, ram[{6'h00, op[0]}]}] = m_acc; m_pc += 16'h1; end
      8'he2: begin m_acc = xm[{8'h00, ram[{6'h00, op[0]}]}]; m_pc += 16'h1; end
      8'h93: begin m_acc = cm[m_dp + {8'h00, m_acc}]; m_pc += 16'h1; end
      8'h83: begin m_pc += 16'h1; m_acc = cm[m_pc + {8'h00, m_acc}]; end
      8'ha2: begin m_cy = ram[7'h20 + 7'(b2[6:3])][b2[2:0]]; m_pc += 16'h2; cyc = 1; end
      8'h92: begin ram[7'h20 + 7'(b2[6:3])][b2[2:0]] = m_cy; m_pc += 16'h2; end
      8'h60: begin m_pc += 16'h2; if (m_acc == 8'h00) m_pc += {{8{b2[7]}}, b2}; end
      8'h12: begin
        m_pc += 16'h3;
        ram[7'(m_sp + 8'h1)] = m_pc[7:0];
        ram[7'(m_sp + 8'h2)] = m_pc[15:8];
        m_sp += 8'h2;
        m_pc = {b2, b3};
      end
      8'h02: m_pc = {b2, b3};
      default: begin m_pc += 16'h1; cyc = 1; end
    endcase
  endtask

  task automatic load_prog();
    logic [7:0] v1, v2, v3, v4, v5, dh;
    logic [7:0] p [$];
    v1 = 8'($urandom) | 8'h01;
    v2 = 8'($urandom);
    v3 = 8'($urandom);
    v4 = 8'($urandom) & 8'hf0;
    v5 = 8'($urandom);
    dh = 8'($urandom);
    // only ram addresses are named directly, never the accumulator's own address
    p = '{8'h74, v1, 8'hf8, 8'h75, 8'h30, v2, 8'h85, 8'h30, 8'h31, 8'he5, 8'h31, 8'he8,
      8'h90, dh, 8'hf8, 8'hf0, 8'h74, 8'h10, 8'h93, 8'he0, 8'hf2, 8'he2, 8'h75, 8'h20, v3,
      8'h75, 8'h21,
      v5, 8'ha2, 8'h03, 8'h92, 8'h0a, 8'he5, 8'h21, 8'h74, 8'h00, 8'h60, 8'h02, 8'h74, 8'hff,
      8'h74, v1, 8'h60, 8'h7f, 8'h12, 8'h02, v4};
    foreach (p[i]) cm[i] = p[i];
    p = '{8'he5, 8'h09, 8'he5, 8'h08, 8'h83, 8'h02, 8'h03, 8'h00};
    foreach (p[i]) cm[16'({8'h02, v4} + i)] = p[i];
    cm[16'h0300] = 8'h02;
    cm[16'h0301] = 8'h03;
    cm[16'h0302] = 8'h00;
  endtask

  task automatic run_prog();
    int cyc, n;
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    m_pc = 16'h0000;
    m_dp = 16'h0000;
    m_acc = 8'h00;
    m_sp = 8'h07;
    m_cy = 1'b0;
    xm.delete();
    for (int k = 0; k < 27; k++) begin
      step(cyc);
      n = 0;
      do begin
        @(posedge clock_i);
        #1;
        n++;
      end while (instr_done_o !== 1'b1 && n < 40);
      if (k > 0) chk_clocks(cyc * 6, n);
      chk_val("pc", m_pc, pc_o);
      chk_val("acc", {8'h00, m_acc}, {8'h00, acc_o});
      chk_val("sp", {8'h00, m_sp}, {8'h00, sp_o});
      chk_val("data_pointer", m_dp, data_pointer_o);
      chk_val("carry", {15'h0000, m_cy}, {15'h0000, carry_o});
    end
    foreach (xm[a]) chk_val("xdata", {8'h00, xm[a]}, {8'h00, mem.xmem[a]});
  endtask

  initial begin
    void'($urandom(54115));
    foreach (cm[i]) cm[i] = 8'($urandom);
    for (int p = 0; p < 2; p++) begin
      load_prog();
      mem.code = cm;
      run_prog();
      $display("program pass %0d finished", p);
    end
    end_of_test();
  end

  initial begin
    repeat (3000) @(posedge clock_i);
    err_count++;
    end_of_test();
  end
endmodule
